// file: hw/wwc_pkg.sv
`default_nettype none
package wwc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int MEM_RATED_NS = 35;
  localparam int CYCLE_RATED_NS = 55;
  // Slower parts stretch the instruction cycle in proportion
  localparam int MEM_ACCESS_NS = 35;
  localparam int INSTR_CYCLE_NS =
    (CYCLE_RATED_NS * MEM_ACCESS_NS + MEM_RATED_NS - 1) / MEM_RATED_NS;
  localparam int CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] PHASE_LAST = 3'(CYCLE_CLKS - 1);
  localparam logic [2:0] PHASE_STROBE = 3'(CYCLE_CLKS - 2);

  // ****************************************
  // Program counter
  // ****************************************
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0004;

  // ****************************************
  // Instruction word
  // ****************************************
  typedef enum logic [1:0] {
    DIN_BUS = 2'b00,
    DIN_IMM = 2'b01,
    DIN_PC = 2'b10,
    DIN_MEM = 2'b11
  } wwc_din_type;

  typedef struct packed {
    logic [5:0] a_sel;
    logic [5:0] b_sel;
    logic [9:0] slice_op_code;
    logic carry_input_bit;
    logic stat_load_en;
    wwc_din_type din_sel;
    logic bus_read;
    logic bus_write;
    logic memory_write_strobe;
    logic mar_load;
    logic jump_en;
    logic cond_test;
    logic [1:0] shift_gate;
    logic [13:0] misc;
    logic [15:0] imm;
  } wwc_instr_type;

  // ****************************************
  // Output groups
  // ****************************************
  typedef struct packed {
    logic [5:0] a_addr;
    logic [5:0] b_addr;
    logic [9:0] slice_op_code;
    logic carry_input_bit;
    logic stat_load_en;
    logic [1:0] shift_gate;
    logic [15:0] din;
  } wwc_slice_type;

  typedef struct packed {
    logic slice_oe;
    logic imm_oe;
    logic [15:0] imm_out;
    logic io_read_en;
    logic [5:0] io_read_sel;
    logic io_write_en;
    logic [5:0] io_write_sel;
    logic memory_write_strobe;
    logic [15:0] memory_address_latch;
    logic [3:0] mem_chip_sel;
    logic [13:0] misc_ctrl;
  } wwc_bus_type;

  // ****************************************
  // Register bus
  // ****************************************
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } wwc_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } wwc_axi_rsp_type;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IR_LO = 8'h08;
  localparam logic [7:0] REG_IR_HI = 8'h0C;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RESET = 1'h0;
  localparam int STAT_RUN_BIT = 16;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage
`default_nettype wire

// file: hw/wwc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module wwc_regs (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire wwc_pkg::wwc_axi_req_type axi_req,
  output wwc_pkg::wwc_axi_rsp_type axi_rsp,
  output logic run,
  input wire logic [15:0] pc,
  input wire logic [2:0] phase,
  input wire logic [63:0] ir
);
  import wwc_pkg::*;

  typedef struct packed {
    logic run;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wwc_axi_rsp_type rsp;
  } wwc_regs_state_type;

  wwc_regs_state_type state;
  wwc_regs_state_type next_state;

  // ****************************************
  // Slave logic
  // ****************************************
  always_comb begin
    next_state = state;
    if (state.rsp.bvalid && axi_req.bready) begin
      next_state.rsp.bvalid = 1'b0;
    end
    if (state.rsp.rvalid && axi_req.rready) begin
      next_state.rsp.rvalid = 1'b0;
    end
    if (axi_req.awvalid && state.rsp.awready) begin
      next_state.aw_have = 1'b1;
      next_state.aw_addr = axi_req.awaddr[7:0];
    end
    if (axi_req.wvalid && state.rsp.wready) begin
      next_state.w_have = 1'b1;
      next_state.w_data = axi_req.wdata;
      next_state.w_strb = axi_req.wstrb;
    end
    // Response waits for both halves and a free write channel
    if (state.aw_have && state.w_have && !state.rsp.bvalid) begin
      next_state.aw_have = 1'b0;
      next_state.w_have = 1'b0;
      next_state.rsp.bvalid = 1'b1;
      next_state.rsp.bresp = AXI_OKAY;
      unique case (state.aw_addr)
        REG_CTRL: begin
          if (state.w_strb[0]) begin
            next_state.run = state.w_data[CTRL_RUN_BIT];
          end
        end
        REG_STATUS, REG_IR_LO, REG_IR_HI: begin
        end
        default: begin
          next_state.rsp.bresp = AXI_SLVERR;
        end
      endcase
    end
    if (axi_req.arvalid && state.rsp.arready) begin
      next_state.rsp.rvalid = 1'b1;
      next_state.rsp.rresp = AXI_OKAY;
      next_state.rsp.rdata = 32'h0000_0000;
      unique case (axi_req.araddr[7:0])
        REG_CTRL: next_state.rsp.rdata[CTRL_RUN_BIT] = state.run;
        REG_STATUS: next_state.rsp.rdata = {12'h000, phase, state.run, pc};
        REG_IR_LO: next_state.rsp.rdata = ir[31:0];
        REG_IR_HI: next_state.rsp.rdata = ir[63:32];
        default: next_state.rsp.rresp = AXI_SLVERR;
      endcase
    end
    next_state.rsp.awready = !next_state.aw_have;
    next_state.rsp.wready = !next_state.w_have;
    next_state.rsp.arready = !next_state.rsp.rvalid;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= '0;
      state.run <= CTRL_RUN_RESET;
      state.rsp.awready <= 1'b1;
      state.rsp.wready <= 1'b1;
      state.rsp.arready <= 1'b1;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign axi_rsp = state.rsp;
  assign run = state.run;

endmodule // wwc_regs
`default_nettype wire

// file: hw/wwc_decode_top.sv
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Instruction is 64 bits: 50 control bits plus 14 free application bits.
// - One instruction equals four consecutive 16-bit words seen from data side.
// - Two leading 6-bit fields address slice operand ports one and two.
// - 12-bit slice field: 10-bit op code, carry input, flag load enable.
// - 2-bit shift field gates slice shift-in and shift-out lines.
// - Slice data input comes from bus, immediate, program counter or memory data.
// - Without bus read, slice output drives the data bus by default.
// - Memory write stores bus value, address load captures it; both allowed.
// - Bus read turns slice off and drives bus from I/O register at first field.
// - Bus write stores bus value into I/O register named by second field.
// - Branch means jump field lets program counter load from data bus.
// - Conditional branch: first field selects condition gating counter load.
// - 14-bit misc field drives peripheral strobes directly, undecoded.
// - Memory load or store takes two instructions: address load, then access.
// - Address load puts slice value or immediate on bus, captures address.
// - Load routes memory data to slice input; store writes slice data.
// - Flag register access uses bus read or bus write select.
// - Jump-and-link: immediate on bus to counter, old counter into slice.
// - Instruction cycle 55 ns with 35 ns memories, stretched for slower; here it rounds up to 6 clocks of 10 ns, 60 ns.
// - Register arithmetic, logic and shifts run inside the slice element.
// - Branches have one delay slot before the new counter takes effect.
// - Upper 14 counter bits address instructions; low two pick chip pair.
module wwc_decode_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  output logic [13:0] instr_addr,
  input wire logic [63:0] instr_data,
  input wire logic [15:0] mem_rdata,
  input wire logic [15:0] data_bus_in,
  input wire logic [63:0] cond_vec,
  output wwc_pkg::wwc_slice_type slice_ctl,
  output wwc_pkg::wwc_bus_type bus_ctl,
  input wire wwc_pkg::wwc_axi_req_type axi_req,
  output wwc_pkg::wwc_axi_rsp_type axi_rsp
);
  import wwc_pkg::*;

  typedef struct packed {
    logic [2:0] phase;
    logic [15:0] pc;
    wwc_instr_type ir;
    wwc_slice_type slice;
    wwc_bus_type bus;
  } wwc_core_state_type;

  wwc_core_state_type state;
  wwc_core_state_type next_state;
  logic run;
  logic cond_hit;
  logic taken;
  logic step;

  // ****************************************
  // Register bus
  // ****************************************
  wwc_regs u_regs (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .axi_req(axi_req),
    .axi_rsp(axi_rsp),
    .run(run),
    .pc(state.pc),
    .phase(state.phase),
    .ir(state.ir)
  );

  // ****************************************
  // Sequencing and decode
  // ****************************************
  always_comb begin
    next_state = state;
    // Condition mux steered by the first select field
    cond_hit = state.ir.cond_test ? cond_vec[state.ir.a_sel] : 1'b1;
    taken = state.ir.jump_en && cond_hit;
    step = run && (state.phase == PHASE_LAST);
    next_state.bus.memory_write_strobe = 1'b0;
    next_state.bus.io_write_en = 1'b0;
    if (run) begin
      if (state.phase == PHASE_LAST) begin
        next_state.phase = 3'h0;
        // Fetch overlaps execution, so the word after a branch still runs
        next_state.ir = instr_data;
        if (taken) begin
          next_state.pc = data_bus_in;
        end else begin
          next_state.pc = state.pc + PC_STEP;
        end
        if (state.ir.mar_load) begin
          next_state.bus.memory_address_latch = data_bus_in;
          next_state.bus.mem_chip_sel = 4'h1 << data_bus_in[1:0];
        end
      end else begin
        next_state.phase = state.phase + 3'h1;
        // Strobes sit in the last clock so the bus has settled by then
        if (state.phase == PHASE_STROBE) begin
          next_state.bus.memory_write_strobe = state.ir.memory_write_strobe;
          next_state.bus.io_write_en = state.ir.bus_write;
        end
      end
    end
    // Slice control straight from the word; the slice does the arithmetic
    next_state.slice.a_addr = next_state.ir.a_sel;
    next_state.slice.b_addr = next_state.ir.b_sel;
    next_state.slice.slice_op_code = next_state.ir.slice_op_code;
    next_state.slice.carry_input_bit = next_state.ir.carry_input_bit;
    next_state.slice.stat_load_en = next_state.ir.stat_load_en;
    next_state.slice.shift_gate = next_state.ir.shift_gate;
    unique case (next_state.ir.din_sel)
      DIN_BUS: next_state.slice.din = data_bus_in;
      DIN_IMM: next_state.slice.din = next_state.ir.imm;
      DIN_PC: next_state.slice.din = next_state.pc;
      DIN_MEM: next_state.slice.din = mem_rdata;
    endcase
    // Bus source: I/O register, else immediate, else the slice
    next_state.bus.io_read_en = next_state.ir.bus_read;
    next_state.bus.io_read_sel = next_state.ir.a_sel;
    next_state.bus.io_write_sel = next_state.ir.b_sel;
    next_state.bus.imm_oe = !next_state.ir.bus_read &&
      (next_state.ir.din_sel == DIN_IMM || next_state.ir.din_sel == DIN_PC);
    next_state.bus.slice_oe = !next_state.ir.bus_read && !next_state.bus.imm_oe;
    next_state.bus.imm_out = next_state.ir.imm;
    next_state.bus.misc_ctrl = next_state.ir.misc;
  end

  // Reset leaves a zero word in place: no strobes, no jump, slice on bus
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state <= '0;
      state.pc <= PC_RESET;
      state.bus.slice_oe <= 1'b1;
      state.bus.mem_chip_sel <= 4'h1;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign instr_addr = state.pc[15:2];
  assign slice_ctl = state.slice;
  assign bus_ctl = state.bus;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  logic [7:0] gap_count;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gap_count <= 8'h00;
    end else if (clk_en && run) begin
      gap_count <= (step) ? 8'h00 : gap_count + 8'h01;
    end
  end

  cycle_length_a : assert property (clk_en && step |-> gap_count == 8'(CYCLE_CLKS - 1))
    else $error("instruction cycle has the wrong length");

  pc_advance_a : assert property (clk_en && step && !taken
    |=> state.pc == $past(state.pc) + PC_STEP)
    else $error("counter did not step by one instruction");

  branch_load_a : assert property (clk_en && step && taken
    |=> state.pc == $past(data_bus_in))
    else $error("taken branch did not load the counter from the bus");

  cond_block_a : assert property (clk_en && step && state.ir.jump_en &&
    state.ir.cond_test && !cond_vec[state.ir.a_sel]
    |=> state.pc == $past(state.pc) + PC_STEP)
    else $error("false condition still loaded the counter");

  delay_slot_a : assert property (clk_en && step && taken
    |=> state.ir == $past(instr_data))
    else $error("word after a branch was not executed");

  mar_capture_a : assert property (clk_en && step && state.ir.mar_load
    |=> bus_ctl.memory_address_latch == $past(data_bus_in)
    && bus_ctl.mem_chip_sel == 4'h1 << bus_ctl.memory_address_latch[1:0])
    else $error("address latch or chip select wrong");

  write_strobe_a : assert property (bus_ctl.memory_write_strobe
    |-> state.phase == PHASE_LAST && state.ir.memory_write_strobe)
    else $error("memory write outside the last clock of its cycle");

  io_write_a : assert property (clk_en && run && state.phase == PHASE_STROBE
    && state.ir.bus_write |=> bus_ctl.io_write_en
    && bus_ctl.io_write_sel == state.ir.b_sel)
    else $error("I/O write strobe missing or misdirected");

  bus_owner_a : assert property (bus_ctl.io_read_en
    |-> !bus_ctl.slice_oe && !bus_ctl.imm_oe && bus_ctl.io_read_sel == state.ir.a_sel)
    else $error("bus read did not take the bus from the slice");

  slice_default_a : assert property (!bus_ctl.io_read_en && !bus_ctl.imm_oe
    |-> bus_ctl.slice_oe)
    else $error("slice not driving an otherwise idle bus");

  din_bus_a : assert property (clk_en && next_state.ir.din_sel == DIN_BUS
    |=> slice_ctl.din == $past(data_bus_in))
    else $error("slice data input not taken from the bus");

  misc_pass_a : assert property (bus_ctl.misc_ctrl == state.ir.misc
    && slice_ctl.slice_op_code == state.ir.slice_op_code)
    else $error("direct fields not passed through");

  branch_taken_c : cover property (clk_en && step && taken ##6 step);
  link_jump_c : cover property (clk_en && step && taken
    && state.ir.din_sel == DIN_PC);
  store_pair_c : cover property (bus_ctl.memory_write_strobe
    && state.ir.mar_load);

endmodule // wwc_decode_top
`default_nettype wire

// file: tb/wwc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Dual-port memory and slice stand-in
// ****************************************
module wwc_mem_model
  import wwc_pkg::*;
#(
  parameter logic [15:0] SLICE_Q = 16'h5A5A,
  parameter logic [15:0] IO_Q = 16'hC300
) (
  input wire logic clk_sys,
  input wire logic [13:0] instr_addr,
  output logic [63:0] instr_data,
  input wire wwc_pkg::wwc_bus_type bus_ctl,
  output logic [15:0] mem_rdata,
  output logic [15:0] data_bus_in
);
  logic [63:0] mem [0:255];
  logic [15:0] last_bus;
  logic [7:0] dw;
  logic [1:0] dl;
  assign dw = bus_ctl.memory_address_latch[9:2];
  assign dl = bus_ctl.memory_address_latch[1:0];
  assign instr_data = mem[instr_addr[7:0]];
  // Lane 0 is the top quarter of the instruction word
  assign mem_rdata = mem[dw][63 - 16 * dl -: 16];
  // Undriven bus flips each clock so a stale value never looks valid
  always_comb begin
    if (bus_ctl.io_read_en)
      data_bus_in = IO_Q ^ {10'h000, bus_ctl.io_read_sel};
    else if (bus_ctl.imm_oe)
      data_bus_in = bus_ctl.imm_out;
    else if (bus_ctl.slice_oe)
      data_bus_in = SLICE_Q;
    else
      data_bus_in = ~last_bus;
  end
  always @(posedge clk_sys) begin
    last_bus <= data_bus_in;
    if (bus_ctl.memory_write_strobe)
      mem[dw][63 - 16 * dl -: 16] <= data_bus_in;
  end
endmodule // wwc_mem_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wwc_pkg::*;
  logic clk_sys;
  logic reset_n;
  logic clk_en;
  logic [13:0] instr_addr;
  logic [63:0] instr_data;
  logic [15:0] mem_rdata;
  logic [15:0] data_bus_in;
  logic [63:0] cond_vec;
  wwc_slice_type slice_ctl;
  wwc_bus_type bus_ctl;
  wwc_axi_req_type req;
  wwc_axi_rsp_type rsp;
  int err_total;
  int n_tests;
  int cnt_mw;
  int cnt_iow;
  int n;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [13:0] hold;

  wwc_decode_top wwc_decode_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .instr_addr(instr_addr), .instr_data(instr_data), .mem_rdata(mem_rdata),
    .data_bus_in(data_bus_in), .cond_vec(cond_vec), .slice_ctl(slice_ctl),
    .bus_ctl(bus_ctl), .axi_req(req), .axi_rsp(rsp));
  wwc_mem_model wwc_mem_model_i (.clk_sys(clk_sys), .instr_addr(instr_addr),
    .instr_data(instr_data), .bus_ctl(bus_ctl), .mem_rdata(mem_rdata),
    .data_bus_in(data_bus_in));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (bus_ctl.memory_write_strobe === 1'b1)
      cnt_mw <= cnt_mw + 1;
    if (bus_ctl.io_write_en === 1'b1)
      cnt_iow <= cnt_iow + 1;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    req.awaddr <= {24'h000000, a};
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (!aw && !w && rsp.bvalid === 1'b1) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
    end
    if (k == 50) begin
      err_total++;
      finish_test();
    end
    @(posedge clk_sys);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic ar;
    ar = 1'b1;
    req.araddr <= {24'h000000, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (!ar && rsp.rvalid === 1'b1) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
      if (ar && rsp.arready === 1'b1) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end
    if (k == 50) begin
      err_total++;
      finish_test();
    end
    @(posedge clk_sys);
  endtask

  // Waits for the next instruction step and returns the clocks it took
  task automatic step(output int c);
    logic [13:0] a;
    a = instr_addr;
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
    end while (instr_addr === a && c < 40);
    if (c >= 40) begin
      err_total++;
      finish_test();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    check("instr_addr", instr_addr, 14'h0000);
    check("slice_ctl", slice_ctl[41:16], 26'h0000000);
    check("reset_din", slice_ctl.din, 16'h5A5A);
    check("slice_oe", bus_ctl.slice_oe, 1'b1);
    check("chip_sel", bus_ctl.mem_chip_sel, 4'h1);
    axi_read(REG_CTRL, rd, rr);
    check("ctrl", {rr, rd}, {AXI_OKAY, 32'h00000000});
    axi_read(8'h10, rd, rr);
    check("unmapped", {rr, rd}, {AXI_SLVERR, 32'h00000000});
    axi_write(REG_STATUS, 32'hFFFFFFFF, rr);
    check("ro_bresp", rr, AXI_OKAY);
    axi_read(REG_STATUS, rd, rr);
    check("status", rd, 32'h00000000);
  endtask

  task automatic t_branch();
    axi_write(REG_CTRL, 32'h00000001, rr);
    check("bresp", rr, AXI_OKAY);
    step(n);
    check("a_addr", slice_ctl.a_addr, 6'h15);
    check("b_addr", slice_ctl.b_addr, 6'h2A);
    check("op", {slice_ctl.slice_op_code, slice_ctl.carry_input_bit}, 11'h78B);
    check("stat_en", slice_ctl.stat_load_en, 1'b1);
    check("shift", slice_ctl.shift_gate, 2'h2);
    check("misc", bus_ctl.misc_ctrl, 14'h2B3C);
    check("imm_bus", {bus_ctl.imm_oe, bus_ctl.imm_out}, 17'h10040);
    check("pc_step", instr_addr, 14'h0001);
    step(n);
    check("cycle", n, 6);
    check("delay_slot", instr_addr, 14'h0010);
  endtask

  task automatic t_memio();
    step(n);
    check("latch", bus_ctl.memory_address_latch, 16'h0009);
    check("chip_sel", bus_ctl.mem_chip_sel, 4'h2);
    check("mem_wr", wwc_mem_model_i.mem[0][63:48], 16'h0009);
    check("mw_cnt", cnt_mw, 1);
    check("io_rd", {bus_ctl.io_read_en, bus_ctl.io_read_sel}, 7'h47);
    check("oe", {bus_ctl.slice_oe, bus_ctl.imm_oe}, 2'b00);
    check("io_wsel", bus_ctl.io_write_sel, 6'h0B);
    axi_read(REG_IR_HI, rd, rr);
    check("ir_hi", {rr, rd}, {AXI_OKAY, 32'h1CB000F0});
    #1;
    check("load_din", slice_ctl.din, 16'hBEEF);
    step(n);
    check("iow_cnt", cnt_iow, 1);
  endtask

  task automatic t_cond_link();
    step(n);
    check("not_taken", instr_addr, 14'h0013);
    step(n);
    check("taken", instr_addr, 14'h0020);
    check("link_reg", slice_ctl.b_addr, 6'h03);
    @(posedge clk_sys);
    #1;
    check("link_din", slice_ctl.din, 16'h0080);
    step(n);
    check("jal_target", instr_addr, 14'h0040);
    check("default_oe", bus_ctl.slice_oe, 1'b1);
  endtask

  task automatic t_stop();
    // Enable low must hold the counter even while running
    clk_en <= 1'b0;
    hold = instr_addr;
    repeat (12) @(posedge clk_sys);
    #1;
    check("freeze", instr_addr, hold);
    clk_en <= 1'b1;
    axi_write(REG_CTRL, 32'h00000000, rr);
    hold = instr_addr;
    repeat (20) @(posedge clk_sys);
    #1;
    check("halt", instr_addr, hold);
    check("strobes", {cnt_mw[3:0], cnt_iow[3:0]}, 8'h11);
  endtask

  initial begin
    clk_en = 1'b1;
    reset_n = 1'b0;
    cond_vec = 64'h0000000000000040;
    req = '0;
    err_total = 0;
    n_tests = 0;
    cnt_mw = 0;
    cnt_iow = 0;
    for (int i = 0; i < 256; i++)
      wwc_mem_model_i.mem[i] = 64'h0;
    wwc_mem_model_i.mem[0] = wwc_instr_type'{a_sel:6'h15, b_sel:6'h2A, slice_op_code:10'h3C5,
      carry_input_bit:1'b1, stat_load_en:1'b1, din_sel:DIN_IMM, jump_en:1'b1,
      shift_gate:2'h2, misc:14'h2B3C, imm:16'h0040, default:'0};
    wwc_mem_model_i.mem[1] = wwc_instr_type'{din_sel:DIN_IMM, memory_write_strobe:1'b1,
      mar_load:1'b1, imm:16'h0009, default:'0};
    wwc_mem_model_i.mem[2] = 64'h1111BEEF22223333;
    wwc_mem_model_i.mem[16] = wwc_instr_type'{a_sel:6'h07, b_sel:6'h0B, din_sel:DIN_MEM,
      bus_read:1'b1, bus_write:1'b1, default:'0};
    wwc_mem_model_i.mem[17] = wwc_instr_type'{a_sel:6'h05, din_sel:DIN_IMM, jump_en:1'b1,
      cond_test:1'b1, default:'0};
    wwc_mem_model_i.mem[18] = wwc_instr_type'{a_sel:6'h06, din_sel:DIN_IMM, jump_en:1'b1,
      cond_test:1'b1, imm:16'h0080, default:'0};
    wwc_mem_model_i.mem[19] = wwc_instr_type'{b_sel:6'h03, din_sel:DIN_PC, jump_en:1'b1,
      imm:16'h0100, default:'0};
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_branch();
    t_memio();
    t_cond_link();
    t_stop();
    finish_test();
  end
endmodule // tb
`default_nettype wire
